// File: hdl/b4sp_fifo.sv
// parameterised word fifo with valid and ready on both sides
`timescale 1ns/100ps
module b4sp_fifo
    import b4sp_pkg::*;
#(
    parameter int W = 18,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // both handshake sides
    b4sp_fifo_if.fifo port
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [PW:0] next_count;
    logic do_push;
    logic do_pop;

    assign port.push_ready = (count != FULL);
    assign port.pop_valid = (count != '0);
    assign port.pop_data = mem[rd_ptr];
    assign do_push = port.push_valid & port.push_ready;
    assign do_pop = port.pop_valid & port.pop_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (do_push) begin
            next_wr_ptr = PW'(wr_ptr + 1'b1);
        end
        if (do_pop) begin
            next_rd_ptr = PW'(rd_ptr + 1'b1);
        end
        if (do_push && !do_pop) begin
            next_count = (PW+1)'(count + 1'b1);
        end else if (do_pop && !do_push) begin
            next_count = (PW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= port.push_data;
        end
    end
endmodule : b4sp_fifo

// File: hdl/b4sp_fifo_if.sv
// handshake bundle between the read pipeline and its word buffer
`timescale 1ns/100ps
interface b4sp_fifo_if #(parameter int W = 18);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport fifo (
        input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data
    );
    modport user (
        output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data
    );
endinterface : b4sp_fifo_if

// File: hdl/b4sp_pkg.sv
// shared constants and types for the burst-of-four double-rate sram port
package b4sp_pkg;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int ADDR_W = 8;
    localparam int BURST = 4;
    localparam int WIDX_W = 2;
    localparam int MEM_AW = ADDR_W + WIDX_W;
    localparam int FIFO_DEPTH = 16;
    // half-cycle ticks remembered by the read pipeline
    localparam int PIPE_W = 9;
    localparam int IN_W = 2 + ADDR_W + 2 + DATA_W + LANES + 1;
    // read latency in half cycles of the link clock
    localparam logic [3:0] LAT_LONG = 4'h5;
    localparam logic [3:0] LAT_SHORT = 4'h2;
    localparam logic [3:0] LAT_ONE = 4'h1;
    localparam logic [WIDX_W-1:0] WIDX_LAST = 2'h3;
    localparam logic [WIDX_W-1:0] WIDX_ONE = 2'h1;
    localparam logic [WIDX_W-1:0] WIDX_ZERO = 2'h0;
    typedef enum logic {
        B4SP_PH_READ = 1'b0,
        B4SP_PH_WRITE = 1'b1
    } b4sp_phase_t;
endpackage : b4sp_pkg

// File: hdl/b4sp_top.sv
// burst-of-four double-rate sram port: capture, array, read pipeline, launch
`timescale 1ns/100ps
module b4sp_top
    import b4sp_pkg::*;
(
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // link clocks and control pins
    input wire logic i_k,
    input wire logic i_kn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_read_port_select_n,
    input wire logic i_write_port_select_n,
    input wire logic i_pll_disable_pin,
    // write data port
    input wire logic [DATA_W-1:0] i_d,
    input wire logic [LANES-1:0] i_byte_write_select_n,
    // read data port
    output logic [DATA_W-1:0] o_q,
    output logic o_read_valid_flag,
    output logic o_echo_clock_out,
    output logic o_echo_clock_out_n
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic s_k;
    logic s_kn;
    logic [ADDR_W-1:0] s_addr;
    logic s_rsel_n;
    logic s_wsel_n;
    logic [DATA_W-1:0] s_d;
    logic [LANES-1:0] s_bws_n;
    logic s_pll_disable_pin;

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {i_k, i_kn, i_addr, i_read_port_select_n, i_write_port_select_n,
                      i_d, i_byte_write_select_n, i_pll_disable_pin};
            sync2 <= sync1;
        end
    end
    assign {s_k, s_kn, s_addr, s_rsel_n, s_wsel_n, s_d, s_bws_n, s_pll_disable_pin} = sync2;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // finds the pipeline slot base..base+3 holding a read, as {hit, index}
    function automatic logic [4:0] b4sp_scan(input logic [PIPE_W-1:0] v,
                                             input logic [3:0] base);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < BURST; i++) begin
            if (v[base + 4'(i)]) begin
                r = {1'b1, 4'(base + 4'(i))};
            end
        end
        return r;
    endfunction : b4sp_scan

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    b4sp_phase_t phase;
    b4sp_phase_t next_phase;
    logic k_prev;
    logic kn_prev;
    logic wr_busy;
    logic next_wr_busy;
    logic [WIDX_W-1:0] wr_idx;
    logic [WIDX_W-1:0] next_wr_idx;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] next_wr_addr;
    logic rd_slot;
    logic next_rd_slot;
    logic [ADDR_W-1:0] slot_addr [2];
    logic [ADDR_W-1:0] next_slot_addr [2];
    logic [PIPE_W-1:0] pipe_v;
    logic [PIPE_W-1:0] next_pipe_v;
    logic [PIPE_W-1:0] pipe_s;
    logic [PIPE_W-1:0] next_pipe_s;
    logic fetch_req;
    logic next_fetch_req;
    logic [MEM_AW-1:0] fetch_addr;
    logic [MEM_AW-1:0] next_fetch_addr;
    logic push_valid;
    logic next_push_valid;
    logic [DATA_W-1:0] next_q;
    logic next_read_valid_flag;

    logic k_rise;
    logic kn_rise;
    logic tick;
    logic rd_cap;
    logic wr_start;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [3:0] lat;
    logic [4:0] fscan;
    logic [4:0] lscan;
    logic fhit;
    logic launch;
    logic stall;

    logic [DATA_W-1:0] mem [2**MEM_AW];
    b4sp_fifo_if #(.W(DATA_W)) rdq ();

    // ------------------------------------------------------------
    // edge detection and address phase
    // ------------------------------------------------------------
    assign k_rise = s_k & ~k_prev;
    assign kn_rise = s_kn & ~kn_prev;
    assign tick = k_rise | kn_rise;
    assign lat = s_pll_disable_pin ? LAT_LONG : LAT_SHORT;

    always_comb begin
        next_phase = phase;
        rd_cap = 1'b0;
        wr_start = 1'b0;
        if (k_rise) begin
            case (phase)
                B4SP_PH_READ: begin
                    rd_cap = ~s_rsel_n;
                    next_phase = B4SP_PH_WRITE;
                end
                B4SP_PH_WRITE: begin
                    wr_start = ~s_wsel_n;
                    next_phase = B4SP_PH_READ;
                end
                default: begin
                    next_phase = B4SP_PH_READ;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // write port: four words into the array, self-timed
    // ------------------------------------------------------------
    always_comb begin
        next_wr_busy = wr_busy;
        next_wr_idx = wr_idx;
        next_wr_addr = wr_addr;
        if (wr_start) begin
            next_wr_busy = 1'b1;
            next_wr_idx = WIDX_ONE;
            next_wr_addr = s_addr;
        end else if (tick && wr_busy) begin
            next_wr_idx = WIDX_W'(wr_idx + 1'b1);
            next_wr_busy = (wr_idx != WIDX_LAST);
        end
    end
    assign mem_we = wr_start | (tick & wr_busy);
    assign mem_wa = wr_start ? {s_addr, WIDX_ZERO} : {wr_addr, wr_idx};

    // ------------------------------------------------------------
    // read port: latency pipeline, fetch, launch
    // ------------------------------------------------------------
    assign stall = push_valid & ~rdq.push_ready;
    assign fscan = b4sp_scan(next_pipe_v, 4'(lat - LAT_ONE));
    assign lscan = b4sp_scan(next_pipe_v, lat);
    // word fetched one tick before launch so a pending write lands first
    assign fhit = tick & fscan[4];
    assign launch = tick & lscan[4];

    always_comb begin
        next_pipe_v = pipe_v;
        next_pipe_s = pipe_s;
        next_rd_slot = rd_slot;
        next_slot_addr = slot_addr;
        if (tick) begin
            next_pipe_v = {pipe_v[PIPE_W-2:0], rd_cap};
            next_pipe_s = {pipe_s[PIPE_W-2:0], rd_slot};
        end
        if (rd_cap) begin
            next_slot_addr[rd_slot] = s_addr;
            next_rd_slot = ~rd_slot;
        end
    end

    always_comb begin
        next_fetch_req = (fetch_req & stall) | fhit;
        next_fetch_addr = fetch_addr;
        next_push_valid = push_valid;
        if (fhit) begin
            next_fetch_addr = {slot_addr[pipe_s[fscan[3:0] - LAT_ONE]],
                               WIDX_W'(fscan[3:0] - 4'(lat - LAT_ONE))};
        end
        if (!stall) begin
            next_push_valid = fetch_req;
        end
    end

    always_comb begin
        next_q = o_q;
        next_read_valid_flag = o_read_valid_flag;
        if (tick) begin
            next_read_valid_flag = launch & rdq.pop_valid;
        end
        if (launch && rdq.pop_valid) begin
            next_q = rdq.pop_data;
        end
    end

    assign rdq.push_valid = push_valid;
    assign rdq.pop_ready = launch;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            phase <= B4SP_PH_READ;
            k_prev <= 1'b0;
            kn_prev <= 1'b0;
            wr_busy <= 1'b0;
            wr_idx <= WIDX_ZERO;
            wr_addr <= '0;
            rd_slot <= 1'b0;
            slot_addr[0] <= '0;
            slot_addr[1] <= '0;
            pipe_v <= '0;
            pipe_s <= '0;
            fetch_req <= 1'b0;
            fetch_addr <= '0;
            push_valid <= 1'b0;
            o_q <= '0;
            o_read_valid_flag <= 1'b0;
            o_echo_clock_out <= 1'b0;
            o_echo_clock_out_n <= 1'b0;
        end else begin
            phase <= next_phase;
            k_prev <= s_k;
            kn_prev <= s_kn;
            wr_busy <= next_wr_busy;
            wr_idx <= next_wr_idx;
            wr_addr <= next_wr_addr;
            rd_slot <= next_rd_slot;
            slot_addr <= next_slot_addr;
            pipe_v <= next_pipe_v;
            pipe_s <= next_pipe_s;
            fetch_req <= next_fetch_req;
            fetch_addr <= next_fetch_addr;
            push_valid <= next_push_valid;
            o_q <= next_q;
            o_read_valid_flag <= next_read_valid_flag;
            o_echo_clock_out <= s_k;
            o_echo_clock_out_n <= s_kn;
        end
    end

    // array with per-lane write and registered read
    always_ff @(posedge i_core_clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (mem_we && !s_bws_n[l]) begin
                mem[mem_wa][l*LANE_W +: LANE_W] <= s_d[l*LANE_W +: LANE_W];
            end
        end
        if (fetch_req && !stall) begin
            rdq.push_data <= mem[fetch_addr];
        end
    end

    b4sp_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_core_clk),
        .i_resetn(i_resetn),
        .port(rdq.fifo)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [PIPE_W-1:0] hist;
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            hist <= '0;
        end else if (tick) begin
            hist <= {hist[PIPE_W-2:0], rd_cap};
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    chk_phase_alternates: assert property (k_rise |=> phase != $past(phase))
        else $error("address phase did not alternate");
    chk_phase_rise_only: assert property ($changed(phase) |-> $past(k_rise))
        else $error("phase moved without a rising edge");
    chk_burst_ends: assert property (tick && wr_busy && !wr_start
                                      && wr_idx == WIDX_LAST |=> !wr_busy)
        else $error("write burst did not end after four words");
    chk_latency_long: assert property ($rose(o_read_valid_flag) && $past(s_pll_disable_pin)
                                       |-> $past(hist[LAT_LONG - LAT_ONE]))
        else $error("read data not 2.5 cycles after address");
    chk_latency_short: assert property ($rose(o_read_valid_flag) && !$past(s_pll_disable_pin)
                                        |-> $past(hist[LAT_SHORT - LAT_ONE]))
        else $error("read data not 1 cycle after address");
    chk_input_hold: assert property (!tick |=> $stable(wr_addr) && $stable(phase))
        else $error("input register changed between edges");
    chk_output_hold: assert property (!tick |=> $stable(o_q)
                                      && $stable(o_read_valid_flag))
        else $error("read output changed between edges");
    chk_valid_on_edge: assert property ($rose(o_read_valid_flag)
                                        |-> $past(launch) && $past(rdq.pop_valid))
        else $error("valid flag raised without a launched word");
    chk_echo_aligned: assert property ($rose(o_read_valid_flag)
                                       |-> $changed(o_echo_clock_out)
                                       || $changed(o_echo_clock_out_n))
        else $error("echo clock not aligned with read data");
    chk_fetch_coherent: assert property (fetch_req |-> !mem_we)
        else $error("array fetch collided with a write");
    chk_fetch_follows: assert property (rd_cap |-> ##[1:200] fetch_req)
        else $error("read not fetched while port busy");
endmodule : b4sp_top

// File: tb/b4sp_ctrl_model.sv
// behavioural memory controller that drives the link pins of the sram port
`timescale 1ns/100ps
module b4sp_ctrl_model
    import b4sp_pkg::*;
(
    // time base
    input wire logic i_core_clk,
    // link pins toward the device
    output logic o_k,
    output logic o_kn,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_read_sel_n,
    output logic o_write_sel_n,
    output logic [DATA_W-1:0] o_d,
    output logic [LANES-1:0] o_byte_sel_n
);
    logic rd_q [64];
    logic wr_q [64];
    logic [ADDR_W-1:0] ra_q [64];
    logic [ADDR_W-1:0] wa_q [64];
    logic [DATA_W-1:0] wd_q [64][4];
    logic [LANES-1:0] bw_q [64][4];
    int nq = 0;

    initial begin
        o_k = 1'b0;
        o_kn = 1'b0;
        o_addr = 8'h00;
        o_read_sel_n = 1'b1;
        o_write_sel_n = 1'b1;
        o_d = 18'h0_0000;
        o_byte_sel_n = 2'h3;
    end

    task automatic post(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                        input logic [ADDR_W-1:0] wa, input logic [4*DATA_W-1:0] wd,
                        input logic [4*LANES-1:0] bw);
        rd_q[nq] = rd;
        wr_q[nq] = wr;
        ra_q[nq] = ra;
        wa_q[nq] = wa;
        for (int i = 0; i < 4; i++) begin
            wd_q[nq][i] = wd[i*DATA_W +: DATA_W];
            bw_q[nq][i] = bw[i*LANES +: LANES];
        end
        nq++;
    endtask : post

    // address and data lines not sampled at the coming edge toggle so stale values never look valid; read and write selects stay high
    task automatic set_edge(input int s, input int e);
        int ws;
        logic rd;
        logic wr;
        logic pw;
        ws = (e >= 2) ? s : s - 1;
        rd = s < nq && e == 0 && rd_q[s];
        wr = s < nq && e == 2 && wr_q[s];
        pw = ws >= 0 && ws < nq && wr_q[ws];
        o_read_sel_n = ~rd;
        o_write_sel_n = ~wr;
        o_addr = rd ? ra_q[s] : (wr ? wa_q[s] : ~o_addr);
        o_d = pw ? wd_q[ws][(e + 2) % 4] : ~o_d;
        o_byte_sel_n = pw ? bw_q[ws][(e + 2) % 4] : ~o_byte_sel_n;
    endtask : set_edge

    // plays all posted slots; clocks stand still before and after
    task automatic run();
        set_edge(0, 0);
        repeat (4) @(negedge i_core_clk);
        for (int s = 0; s < nq; s++) begin
            for (int e = 0; e < 4; e++) begin
                o_k = ~e[0];
                o_kn = e[0];
                repeat (4) @(negedge i_core_clk);
                set_edge((e < 3) ? s : s + 1, (e + 1) % 4);
                repeat (4) @(negedge i_core_clk);
            end
        end
        o_kn = 1'b0;
        nq = 0;
    endtask : run
endmodule : b4sp_ctrl_model

// File: tb/b4sp_tb_top.sv
// self-checking bench for the burst-of-four double-rate sram port
`timescale 1ns/100ps
module b4sp_tb_top import b4sp_pkg::*;;
    localparam int LIMIT = 20000;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic pll_disable_pin = 1'b0;
    logic k, kn, rsel_n, wsel_n, vld, eck, eckn;
    logic eck_q = 1'b0;
    logic eckn_q = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d, q;
    logic [LANES-1:0] bsel_n;
    logic [31:0] seed = 32'h0000_0059;
    logic [DATA_W-1:0] ref_mem [1024];
    int cyc = 0;
    int failures = 0;
    int n_checks = 0;
    int wl_cyc [$];
    int wl_idx [$];
    logic [DATA_W-1:0] wl_d [$];
    logic [LANES-1:0] wl_bw [$];
    int ex_cyc [$];
    int ex_idx [$];

    b4sp_top i_b4sp_top (.i_core_clk(core_clk), .i_resetn(resetn), .i_k(k), .i_kn(kn),
        .i_addr(addr), .i_read_port_select_n(rsel_n), .i_write_port_select_n(wsel_n),
        .i_pll_disable_pin(pll_disable_pin), .i_d(d), .i_byte_write_select_n(bsel_n), .o_q(q),
        .o_read_valid_flag(vld), .o_echo_clock_out(eck), .o_echo_clock_out_n(eckn));
    b4sp_ctrl_model i_b4sp_ctrl_model (.i_core_clk(core_clk), .o_k(k), .o_kn(kn),
        .o_addr(addr), .o_read_sel_n(rsel_n), .o_write_sel_n(wsel_n), .o_d(d),
        .o_byte_sel_n(bsel_n));

    always #5 core_clk = ~core_clk;

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures++;
            $display("[ERR] %0t run did not finish", $time);
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] nw, input logic [LANES-1:0] bw_n);
        logic [DATA_W-1:0] r;
        r = old;
        for (int l = 0; l < LANES; l++) begin
            if (!bw_n[l]) r[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
        end
        return r;
    endfunction : merge

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                       input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // a word written by the fetch tick, one tick before a launch, is visible to that launch
    always @(negedge core_clk) begin
        if (resetn) begin
            while (wl_cyc.size() > 0 && wl_cyc[0] + 8 <= cyc) begin
                ref_mem[wl_idx[0]] = merge(ref_mem[wl_idx[0]], wl_d.pop_front(),
                                           wl_bw.pop_front());
                void'(wl_idx.pop_front());
                void'(wl_cyc.pop_front());
            end
            if (ex_cyc.size() > 0 && ex_cyc[0] < cyc) begin
                chk(DATA_W'(vld), DATA_W'(2), "read word missed its slot");
                void'(ex_cyc.pop_front());
                void'(ex_idx.pop_front());
            end
            if ((eck && !eck_q) || (eckn && !eckn_q)) begin
                if (ex_cyc.size() > 0 && ex_cyc[0] == cyc) begin
                    chk(DATA_W'(vld), DATA_W'(1), "valid flag");
                    chk(q, ref_mem[ex_idx[0]], "read data");
                    void'(ex_cyc.pop_front());
                    void'(ex_idx.pop_front());
                end else begin
                    chk(DATA_W'(vld), DATA_W'(0), "flag without word");
                end
            end
        end
        eck_q = eck;
        eckn_q = eckn;
    end

    task automatic do_reset(input logic pll);
        resetn = 1'b0;
        pll_disable_pin = pll;
        repeat (19) @(negedge core_clk);
        chk(q, DATA_W'(0), "read data in reset");
        chk(DATA_W'({vld, eck, eckn}), DATA_W'(0), "flags in reset");
        @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask : do_reset

    // n slots plus three idle slots that drain the read pipe
    task automatic do_run(input int n, input bit fill);
        int p;
        int lat;
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] ra;
        logic [ADDR_W-1:0] wa;
        logic [95:0] rr;
        logic [31:0] r;
        @(negedge core_clk);
        p = cyc + 4;
        lat = pll_disable_pin ? 5 : 2;
        for (int j = 0; j < n + 3; j++) begin
            r = rnd();
            rr = {rnd(), rnd(), rnd()};
            ra = r[3] ? 8'hff : {5'h00, r[2:0]};
            wa = r[7] ? 8'hff : {5'h00, r[6:4]};
            rd = j < n && !fill && r[9:8] != 2'h0;
            wr = j < n && (fill || j == 0 || r[11:10] != 2'h0);
            if (fill) wa = (j == n - 1) ? 8'hff : j[7:0];
            if (j == 0 && !fill) wa = ra;
            if (fill) rr[95:88] = 8'h00;
            i_b4sp_ctrl_model.post(rd, ra, wr, wa, rr[71:0], rr[95:88]);
            for (int i = 0; i < 4; i++) begin
                if (rd) begin
                    ex_cyc.push_back(p + 32 * j + 8 * (lat + i) + 3);
                    ex_idx.push_back({ra, i[1:0]});
                end
                if (wr) begin
                    wl_cyc.push_back(p + 32 * j + 16 + 8 * i);
                    wl_idx.push_back({wa, i[1:0]});
                    wl_d.push_back(rr[i*DATA_W +: DATA_W]);
                    wl_bw.push_back(rr[88 + i*LANES +: LANES]);
                end
            end
        end
        i_b4sp_ctrl_model.run();
    endtask : do_run

    initial begin
        for (int m = 0; m < 2; m++) begin
            do_reset(m[0]);
            do_run(9, 1'b1);
            do_run(12, 1'b0);
            do_run(12, 1'b0);
        end
        chk(DATA_W'(ex_cyc.size()), DATA_W'(0), "reads left unanswered");
        end_sim();
    end
endmodule : b4sp_tb_top
